// ===== rtl/vjc_pkg.sv
// Purpose: shared constants and types of the user scan chain block
// Assumes: lsb-first shifting on every chain
// Notes:   instruction codes are local choices, all ones is the bypass
package vjc_pkg;

  // ==========================================================
  // instruction chain
  localparam int          IR_W       = 4;
  localparam logic [3:0]  INS_EXTEST = 4'h0;
  localparam logic [3:0]  INS_IDCODE = 4'h1;
  localparam logic [3:0]  INS_VDATA  = 4'h2;
  localparam logic [3:0]  INS_VINSTR = 4'h3;
  localparam logic [3:0]  INS_BYPASS = 4'hf;
  localparam logic [3:0]  IR_RESET   = 4'h1;
  localparam logic [3:0]  IR_CAPTURE = 4'h1;

  // ==========================================================
  // data chains
  localparam int          ID_W       = 32;
  localparam int          BND_W      = 16;
  localparam int          NODE_AW    = 7;
  localparam int          NODE_MAX   = 128;
  localparam int          NI_W       = 8;
  localparam int          ND_W       = 32;
  localparam int          VIR_W      = NODE_AW + NI_W;
  localparam int          SYNC_STAGES = 2;

  // ==========================================================
  // access port states
  typedef enum logic [3:0] {
    TLR, RTI,
    SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } vjc_tap_type;

  typedef enum logic [2:0] {
    CH_BND, CH_ID, CH_BYP, CH_VIR, CH_VDR
  } vjc_chain_type;

endpackage : vjc_pkg

// ===== rtl/vjc_mem_if.sv
// Purpose: carrier between the scan logic and the node instruction store
// Assumes: both ends on the test clock
// Notes:   read data arrive one edge after the address
`timescale 1ns/1ps
interface vjc_mem_if #(
  parameter int AW = 7,
  parameter int DW = 8
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport host (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : vjc_mem_if

// ===== rtl/vjc_node_mem.sv
// Purpose: per-node instruction hold store, one word per user node
// Assumes: single clock, one write and one read port
// Notes:   read data come from a register
`timescale 1ns/1ps
module vjc_node_mem #(
  parameter int AW    = 7,
  parameter int DW    = 8,
  parameter int DEPTH = 128
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // store port
  vjc_mem_if.mem   bus
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] words;
    logic [DW-1:0]            rdata;
  } vjc_mem_state_type;

  vjc_mem_state_type st_ff;
  vjc_mem_state_type nxt_st;

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = st_ff.words[bus.raddr];
    if (bus.we) begin
      nxt_st.words[bus.waddr] = bus.wdata;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.rdata = st_ff.rdata;

endmodule : vjc_node_mem

// ===== rtl/vjc_user_scan.sv
// Purpose: test access port with instruction, boundary, id, bypass and two user chains
// Assumes: host drives tms/tdi, samples tdo on rising test clock edges
// Notes:   user node words reach the core clock through a toggle handshake
//
// Function
// - tdi bit shifts into the selected instruction or data chain
// - selected chain serial output drives tdo
// - tms alone sequences the access port state machine
// - all chain and state logic runs on the test clock
// - four pins plus optional test reset that resets the state machine
// - instruction hold selects which data chain sits between tdi and tdo
// - each instruction code enables exactly one data chain
// - instruction, boundary and user chains are a shift stage plus a parallel hold stage; id and bypass are shift stage only
// - hold stages stay unchanged while data shifts
// - boundary chain primary; id, bypass and custom chains exist
// - two data chains reserved for user on-chip applications
// - at most 128 user nodes share the port
// - each user node has a unique address identifier
// - hub routes the single port to the addressed node
// - state machine routes data between instruction and data chains
// - node instruction path on one user code, node data path on other
// - active node keeps serial continuity from tdi to tdo
// - node register shifts are carried inside an ordinary data shift
`timescale 1ns/1ps
module vjc_user_scan #(
  // arbitrary identification value
  parameter logic [31:0] ID_VALUE = 32'h1234_5671
) (
  // test port
  input  wire logic                         tck_i,
  input  wire logic                         tms_i,
  input  wire logic                         tdi_i,
  input  wire logic                         trst_n_i,
  output logic                              tdo_o,
  output logic                              tdo_oe_o,
  // boundary hold value
  output logic [vjc_pkg::BND_W-1:0]         boundary_o,
  // core clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         reset_i,
  // user node words on the core clock
  output logic [vjc_pkg::NODE_AW-1:0]       node_addr_o,
  output logic [vjc_pkg::NI_W-1:0]          node_instr_o,
  output logic [vjc_pkg::ND_W-1:0]          node_data_o,
  output logic                              node_strobe_o
);

  // ==========================================================
  // state of the test clock domain
  typedef struct packed {
    vjc_pkg::vjc_tap_type               tap;
    logic [vjc_pkg::IR_W-1:0]           ir_sh;
    logic [vjc_pkg::IR_W-1:0]           ir_hold;
    logic [vjc_pkg::BND_W-1:0]          bnd_sh;
    logic [vjc_pkg::BND_W-1:0]          bnd_hold;
    logic [vjc_pkg::ID_W-1:0]           id_sh;
    logic                               byp_sh;
    logic [vjc_pkg::VIR_W-1:0]          vir_sh;
    logic [vjc_pkg::NODE_AW-1:0]        vir_addr;
    logic [vjc_pkg::ND_W-1:0]           vdr_sh;
    logic [vjc_pkg::ND_W-1:0]           vdr_hold;
  } vjc_tck_state_type;

  // node hand-over words on the test clock; only reset_i clears them,
  // so a test reset cannot flip the toggle and fake a node update
  typedef struct packed {
    logic [vjc_pkg::NODE_AW-1:0]        addr;
    logic [vjc_pkg::NI_W-1:0]           instr;
    logic [vjc_pkg::ND_W-1:0]           data;
    logic                               tgl;
  } vjc_hand_state_type;

  // state of the falling-edge output stage
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } vjc_out_state_type;

  // state of the core clock domain
  typedef struct packed {
    logic [vjc_pkg::SYNC_STAGES-1:0]    sync;
    logic                               seen;
    logic [vjc_pkg::NODE_AW-1:0]        addr;
    logic [vjc_pkg::NI_W-1:0]           instr;
    logic [vjc_pkg::ND_W-1:0]           data;
    logic                               strobe;
  } vjc_core_state_type;

  vjc_tck_state_type  tk_ff;
  vjc_tck_state_type  nxt_tk;
  vjc_hand_state_type hd_ff;
  vjc_hand_state_type nxt_hd;
  vjc_out_state_type  ot_ff;
  vjc_out_state_type  nxt_ot;
  vjc_core_state_type cr_ff;
  vjc_core_state_type nxt_cr;

  vjc_pkg::vjc_chain_type sel;
  logic                   tck_rst;
  logic                   dr_out;

  vjc_mem_if #(.AW(vjc_pkg::NODE_AW), .DW(vjc_pkg::NI_W)) mem_bus ();

  // ==========================================================
  // functions

  function automatic vjc_pkg::vjc_tap_type tap_next(
    input vjc_pkg::vjc_tap_type s,
    input logic                 m
  );
    vjc_pkg::vjc_tap_type n;
    n = s;
    case (s)
      vjc_pkg::TLR:    n = m ? vjc_pkg::TLR    : vjc_pkg::RTI;
      vjc_pkg::RTI:    n = m ? vjc_pkg::SEL_DR : vjc_pkg::RTI;
      vjc_pkg::SEL_DR: n = m ? vjc_pkg::SEL_IR : vjc_pkg::CAP_DR;
      vjc_pkg::CAP_DR: n = m ? vjc_pkg::EX1_DR : vjc_pkg::SH_DR;
      vjc_pkg::SH_DR:  n = m ? vjc_pkg::EX1_DR : vjc_pkg::SH_DR;
      vjc_pkg::EX1_DR: n = m ? vjc_pkg::UPD_DR : vjc_pkg::PAU_DR;
      vjc_pkg::PAU_DR: n = m ? vjc_pkg::EX2_DR : vjc_pkg::PAU_DR;
      vjc_pkg::EX2_DR: n = m ? vjc_pkg::UPD_DR : vjc_pkg::SH_DR;
      vjc_pkg::UPD_DR: n = m ? vjc_pkg::SEL_DR : vjc_pkg::RTI;
      vjc_pkg::SEL_IR: n = m ? vjc_pkg::TLR    : vjc_pkg::CAP_IR;
      vjc_pkg::CAP_IR: n = m ? vjc_pkg::EX1_IR : vjc_pkg::SH_IR;
      vjc_pkg::SH_IR:  n = m ? vjc_pkg::EX1_IR : vjc_pkg::SH_IR;
      vjc_pkg::EX1_IR: n = m ? vjc_pkg::UPD_IR : vjc_pkg::PAU_IR;
      vjc_pkg::PAU_IR: n = m ? vjc_pkg::EX2_IR : vjc_pkg::PAU_IR;
      vjc_pkg::EX2_IR: n = m ? vjc_pkg::UPD_IR : vjc_pkg::SH_IR;
      vjc_pkg::UPD_IR: n = m ? vjc_pkg::SEL_DR : vjc_pkg::RTI;
      default:         n = vjc_pkg::TLR;
    endcase
    return n;
  endfunction : tap_next

  // one chain per code, unknown codes fall to bypass
  function automatic vjc_pkg::vjc_chain_type chain_of(
    input logic [vjc_pkg::IR_W-1:0] ir
  );
    vjc_pkg::vjc_chain_type c;
    case (ir)
      vjc_pkg::INS_EXTEST: c = vjc_pkg::CH_BND;
      vjc_pkg::INS_IDCODE: c = vjc_pkg::CH_ID;
      vjc_pkg::INS_VINSTR: c = vjc_pkg::CH_VIR;
      vjc_pkg::INS_VDATA:  c = vjc_pkg::CH_VDR;
      default:             c = vjc_pkg::CH_BYP;
    endcase
    return c;
  endfunction : chain_of

  // ==========================================================
  // test clock domain

  // optional test reset forces the state machine home
  assign tck_rst = reset_i | ~trst_n_i;
  assign sel     = chain_of(tk_ff.ir_hold);

  // node address width bounds the node count
  // address picks the node instruction word
  assign mem_bus.raddr = tk_ff.vir_addr;
  // node instruction path write on its own update
  assign mem_bus.we    = (tk_ff.tap == vjc_pkg::UPD_DR) && (sel == vjc_pkg::CH_VIR);
  assign mem_bus.waddr = tk_ff.vir_sh[vjc_pkg::VIR_W-1 -: vjc_pkg::NODE_AW];
  assign mem_bus.wdata = tk_ff.vir_sh[vjc_pkg::NI_W-1:0];

  always_comb begin
    nxt_tk = tk_ff;
    // tms is the only sequencing input
    nxt_tk.tap = tap_next(tk_ff.tap, tms_i);
    case (tk_ff.tap)
      vjc_pkg::TLR: begin
        nxt_tk.ir_hold = vjc_pkg::IR_RESET;
      end
      vjc_pkg::CAP_IR: begin
        nxt_tk.ir_sh = vjc_pkg::IR_CAPTURE;
      end
      vjc_pkg::SH_IR: begin
        nxt_tk.ir_sh = {tdi_i, tk_ff.ir_sh[vjc_pkg::IR_W-1:1]};
      end
      vjc_pkg::UPD_IR: begin
        nxt_tk.ir_hold = tk_ff.ir_sh;
      end
      vjc_pkg::CAP_DR: begin
        case (sel)
          vjc_pkg::CH_BND: nxt_tk.bnd_sh = tk_ff.bnd_hold;
          vjc_pkg::CH_ID:  nxt_tk.id_sh  = ID_VALUE;
          vjc_pkg::CH_VIR: nxt_tk.vir_sh = {tk_ff.vir_addr, mem_bus.rdata};
          vjc_pkg::CH_VDR: nxt_tk.vdr_sh = tk_ff.vdr_hold;
          default:         nxt_tk.byp_sh = 1'b0;
        endcase
      end
      vjc_pkg::SH_DR: begin
        // tdi into the selected data chain
        // node registers ride a plain data shift
        case (sel)
          vjc_pkg::CH_BND: nxt_tk.bnd_sh = {tdi_i, tk_ff.bnd_sh[vjc_pkg::BND_W-1:1]};
          vjc_pkg::CH_ID:  nxt_tk.id_sh  = {tdi_i, tk_ff.id_sh[vjc_pkg::ID_W-1:1]};
          vjc_pkg::CH_VIR: nxt_tk.vir_sh = {tdi_i, tk_ff.vir_sh[vjc_pkg::VIR_W-1:1]};
          vjc_pkg::CH_VDR: nxt_tk.vdr_sh = {tdi_i, tk_ff.vdr_sh[vjc_pkg::ND_W-1:1]};
          default:         nxt_tk.byp_sh = tdi_i;
        endcase
      end
      vjc_pkg::UPD_DR: begin
        // shift stage feeds its own hold stage
        case (sel)
          vjc_pkg::CH_BND: begin
            nxt_tk.bnd_hold = tk_ff.bnd_sh;
          end
          vjc_pkg::CH_VIR: begin
            nxt_tk.vir_addr = tk_ff.vir_sh[vjc_pkg::VIR_W-1 -: vjc_pkg::NODE_AW];
          end
          vjc_pkg::CH_VDR: begin
            nxt_tk.vdr_hold = tk_ff.vdr_sh;
          end
          default: begin
            nxt_tk.byp_sh = tk_ff.byp_sh;
          end
        endcase
      end
      default: begin
        nxt_tk.tap = tap_next(tk_ff.tap, tms_i);
      end
    endcase
  end

  // chain logic on the test clock
  always_ff @(posedge tck_i or posedge tck_rst) begin
    if (tck_rst) begin
      tk_ff         <= '0;
      tk_ff.tap     <= vjc_pkg::TLR;
      tk_ff.ir_hold <= vjc_pkg::IR_RESET;
    end else begin
      tk_ff <= nxt_tk;
    end
  end

  // user data chain delivers address, instruction and data to the node
  always_comb begin
    nxt_hd = hd_ff;
    if ((tk_ff.tap == vjc_pkg::UPD_DR) && (sel == vjc_pkg::CH_VDR)) begin
      nxt_hd.addr  = tk_ff.vir_addr;
      nxt_hd.instr = mem_bus.rdata;
      nxt_hd.data  = tk_ff.vdr_sh;
      nxt_hd.tgl   = ~hd_ff.tgl;
    end
  end

  always_ff @(posedge tck_i or posedge reset_i) begin
    if (reset_i) begin
      hd_ff <= '0;
    end else begin
      hd_ff <= nxt_hd;
    end
  end

  vjc_node_mem #(
    .AW    (vjc_pkg::NODE_AW),
    .DW    (vjc_pkg::NI_W),
    .DEPTH (vjc_pkg::NODE_MAX)
  ) u_node_mem (
    .clk_i (tck_i),
    .rst_i (tck_rst),
    .bus   (mem_bus.mem)
  );

  // ==========================================================
  // serial output on the falling edge

  // boundary, id, bypass and user chains on the output mux
  // active node chain closes tdi to tdo
  always_comb begin
    case (sel)
      vjc_pkg::CH_BND: dr_out = tk_ff.bnd_sh[0];
      vjc_pkg::CH_ID:  dr_out = tk_ff.id_sh[0];
      vjc_pkg::CH_VIR: dr_out = tk_ff.vir_sh[0];
      vjc_pkg::CH_VDR: dr_out = tk_ff.vdr_sh[0];
      default:         dr_out = tk_ff.byp_sh;
    endcase
  end

  always_comb begin
    nxt_ot        = ot_ff;
    nxt_ot.tdo_oe = 1'b0;
    if (tk_ff.tap == vjc_pkg::SH_IR) begin
      nxt_ot.tdo    = tk_ff.ir_sh[0];
      nxt_ot.tdo_oe = 1'b1;
    end else if (tk_ff.tap == vjc_pkg::SH_DR) begin
      nxt_ot.tdo    = dr_out;
      nxt_ot.tdo_oe = 1'b1;
    end
  end

  always_ff @(negedge tck_i or posedge tck_rst) begin
    if (tck_rst) begin
      ot_ff <= '0;
    end else begin
      ot_ff <= nxt_ot;
    end
  end

  assign tdo_o      = ot_ff.tdo;
  assign tdo_oe_o   = ot_ff.tdo_oe;
  assign boundary_o = tk_ff.bnd_hold;

  // ==========================================================
  // core clock domain
  // snapshot words stay frozen until the next data update, which is
  // many test clocks away, so only the toggle needs synchronising

  always_comb begin
    nxt_cr        = cr_ff;
    nxt_cr.sync   = {cr_ff.sync[0], hd_ff.tgl};
    nxt_cr.strobe = 1'b0;
    if (cr_ff.sync[1] != cr_ff.seen) begin
      nxt_cr.seen   = cr_ff.sync[1];
      nxt_cr.addr   = hd_ff.addr;
      nxt_cr.instr  = hd_ff.instr;
      nxt_cr.data   = hd_ff.data;
      nxt_cr.strobe = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cr_ff <= '0;
    end else begin
      cr_ff <= nxt_cr;
    end
  end

  assign node_addr_o   = cr_ff.addr;
  assign node_instr_o  = cr_ff.instr;
  assign node_data_o   = cr_ff.data;
  assign node_strobe_o = cr_ff.strobe;

endmodule : vjc_user_scan

// ===== verification/vjc_host_model.sv
// Purpose: test host model that clocks frames into the scan port
// Assumes: test clock stands low between frames, 64 ns period
// Notes:   idle tdi shows the inverse of its last bit, no pull on it
`timescale 1ns/1ps
module vjc_host_model (
  // test port
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  task automatic step(input logic m, input logic d, output logic q);
    #1;
    tms_o = m;
    tdi_o = d;
    #31;
    tck_o = 1'b1;
    q = tdo_i;
    #32;
    tck_o = 1'b0;
  endtask : step

  // five ones always reach reset, then settle in idle
  task automatic park();
    logic q;
    repeat (5) step(1'b1, ~tdi_o, q);
    step(1'b0, ~tdi_o, q);
  endtask : park

  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    step(1'b1, ~tdi_o, q);
    if (ir) step(1'b1, ~tdi_o, q);
    step(1'b0, ~tdi_o, q);
    step(1'b0, ~tdi_o, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi_o, q);
    step(1'b0, ~tdi_o, q);
  endtask : scan
endmodule : vjc_host_model

// ===== verification/vjc_user_scan_asserts.sv
// Purpose: concurrent checks on the scan port and node word outputs
// Assumes: test logic is reset by reset_i or by trst_n_i low
// Notes:   a shadow state machine follows tms to judge the port
`timescale 1ns/1ps
module vjc_user_scan_asserts (
  // test port
  input wire logic                        tck_i,
  input wire logic                        tms_i,
  input wire logic                        tdi_i,
  input wire logic                        trst_n_i,
  input wire logic                        tdo_o,
  input wire logic                        tdo_oe_o,
  input wire logic [vjc_pkg::BND_W-1:0]   boundary_o,
  // core side
  input wire logic                        core_clk_i,
  input wire logic                        reset_i,
  input wire logic [vjc_pkg::NODE_AW-1:0] node_addr_o,
  input wire logic [vjc_pkg::NI_W-1:0]    node_instr_o,
  input wire logic [vjc_pkg::ND_W-1:0]    node_data_o,
  input wire logic                        node_strobe_o
);
  // ==========================================================
  // shadow state, next state per tms kept as nibble tables
  localparam logic [63:0] NXT0 = 64'h1bdd_bba1_4664_4311;
  localparam logic [63:0] NXT1 = 64'h2fef_cc02_8785_5920;
  wire logic  tck_rst = reset_i | ~trst_n_i;
  logic [3:0] st_ff;
  logic [3:0] ir_sh_ff;
  logic [3:0] ir_ff;
  logic       seen_ff;
  // seen_ff hides the stale sample history across a stopped-clock reset
  always_ff @(posedge tck_i or posedge tck_rst) begin
    if (tck_rst) begin
      st_ff    <= 4'h0;
      ir_sh_ff <= 4'h0;
      ir_ff    <= vjc_pkg::IR_RESET;
      seen_ff  <= 1'b0;
    end else begin
      st_ff   <= tms_i ? NXT1[st_ff*4 +: 4] : NXT0[st_ff*4 +: 4];
      seen_ff <= 1'b1;
      if (st_ff == vjc_pkg::CAP_IR) ir_sh_ff <= vjc_pkg::IR_CAPTURE;
      if (st_ff == vjc_pkg::SH_IR) ir_sh_ff <= {tdi_i, ir_sh_ff[3:1]};
      if (st_ff == vjc_pkg::UPD_IR) ir_ff <= ir_sh_ff;
      if (st_ff == vjc_pkg::TLR) ir_ff <= vjc_pkg::IR_RESET;
    end
  end

  // ==========================================================
  // test clock domain
  chk_oe_shift_dr: assert property (@(posedge tck_i) disable iff (tck_rst)
    st_ff == vjc_pkg::SH_DR |-> tdo_oe_o) else $error("tdo idle in data shift");
  chk_oe_shift_ir: assert property (@(posedge tck_i) disable iff (tck_rst)
    st_ff == vjc_pkg::SH_IR |-> tdo_oe_o) else $error("tdo idle in instruction shift");
  chk_oe_quiet: assert property (@(posedge tck_i) disable iff (tck_rst)
    !(st_ff inside {vjc_pkg::SH_DR, vjc_pkg::SH_IR}) |-> !tdo_oe_o) else $error("tdo driven outside shift");
  chk_ir_capture: assert property (@(posedge tck_i) disable iff (tck_rst)
    st_ff == vjc_pkg::SH_IR && $past(st_ff) == vjc_pkg::CAP_IR |-> tdo_o) else $error("bad first instruction bit");
  chk_tms_reset: assert property (@(posedge tck_i) disable iff (tck_rst)
    tms_i [*5] |-> ##1 !tdo_oe_o) else $error("tms ones did not quiet tdo");
  chk_bnd_update: assert property (@(posedge tck_i) disable iff (tck_rst)
    seen_ff && $changed(boundary_o) |-> ir_ff == vjc_pkg::INS_EXTEST &&
    (st_ff == vjc_pkg::UPD_DR || $past(st_ff) == vjc_pkg::UPD_DR)) else $error("boundary moved off update");

  // ==========================================================
  // core clock domain
  chk_node_words: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $changed({node_addr_o, node_instr_o, node_data_o}) |-> node_strobe_o) else $error("node words moved silently");
  chk_strobe_gap: assert property (@(posedge core_clk_i) disable iff (reset_i)
    node_strobe_o |=> !node_strobe_o [*3]) else $error("strobe too long");
  chk_node_reset: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $fell(reset_i) |-> node_data_o == '0 && node_addr_o == '0 && !node_strobe_o) else $error("node words not cleared");

  cover property (@(posedge tck_i) disable iff (tck_rst) st_ff == vjc_pkg::UPD_IR);
  cover property (@(posedge tck_i) disable iff (tck_rst) seen_ff && $changed(boundary_o));
  cover property (@(posedge core_clk_i) disable iff (reset_i) node_strobe_o);
endmodule : vjc_user_scan_asserts

bind vjc_user_scan vjc_user_scan_asserts u_asserts (
  .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .trst_n_i(trst_n_i), .tdo_o(tdo_o),
  .tdo_oe_o(tdo_oe_o), .boundary_o(boundary_o), .core_clk_i(core_clk_i), .reset_i(reset_i),
  .node_addr_o(node_addr_o), .node_instr_o(node_instr_o), .node_data_o(node_data_o),
  .node_strobe_o(node_strobe_o)
);

// ===== verification/test_jtag_user_scan_chain.sv
// Purpose: self-checking bench for the user scan chain block
// Assumes: host model clocks frames, core clock 20 MHz
// Notes:   rows run in order, later rows expect what earlier ones left
`timescale 1ns/1ps
module test_jtag_user_scan_chain;
  // arbitrary identification value
  localparam logic [31:0] ID = 32'h0a5c_3e01;
  typedef struct packed {
    logic [3:0]  code;
    logic [5:0]  n;
    logic [31:0] din;
    logic [31:0] dout;
    logic [15:0] bnd;
    logic [31:0] nd;
  } vjc_row_type;
  logic        core_clk_i, reset_i, trst_n_i, tck, tms, tdi, tdo, tdo_oe, strobe, q;
  logic [15:0] bnd;
  logic [6:0]  addr;
  logic [7:0]  instr;
  logic [31:0] data, d;
  wire         tdo_line;
  int          n_errors = 0, checks = 0, cycles = 0, n_strobes = 0;
  vjc_row_type rows [10] = '{
    '{4'h1, 6'd32, 32'h0, ID, 16'h0, 32'h0},
    '{4'h0, 6'd16, 32'ha5c3, 32'h0, 16'ha5c3, 32'h0},
    '{4'h0, 6'd16, 32'h5a3c, 32'ha5c3, 16'h5a3c, 32'h0},
    '{4'hf, 6'd8, 32'h96, 32'h2c, 16'h5a3c, 32'h0},
    '{4'h7, 6'd8, 32'h96, 32'h2c, 16'h5a3c, 32'h0},
    '{4'h3, 6'd15, 32'h053c, 32'h0, 16'h5a3c, 32'h0},
    '{4'h3, 6'd15, 32'h0577, 32'h053c, 16'h5a3c, 32'h0},
    '{4'h2, 6'd32, 32'hdead_beef, 32'h0, 16'h5a3c, 32'hdead_beef},
    '{4'h2, 6'd32, 32'h1357_9bdf, 32'hdead_beef, 16'h5a3c, 32'h1357_9bdf},
    '{4'h2, 6'd32, 32'h2468_ace0, 32'h1357_9bdf, 16'h5a3c, 32'h2468_ace0}};

  // tdo floats when the device lets go of it
  assign tdo_line = tdo_oe ? tdo : 1'bz;

  vjc_user_scan #(.ID_VALUE(ID)) DUT (
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n_i), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .boundary_o(bnd), .core_clk_i(core_clk_i), .reset_i(reset_i), .node_addr_o(addr),
    .node_instr_o(instr), .node_data_o(data), .node_strobe_o(strobe));
  vjc_host_model host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_line));

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic load_ir(input logic [3:0] code);
    logic [31:0] cap;
    host.scan(1'b1, 4, {28'h0, code}, cap);
    cmp(cap, 32'h1, "instruction capture");
  endtask : load_ir

  always @(posedge core_clk_i) begin
    cycles++;
    if (strobe === 1'b1) n_strobes++;
    if (cycles == 4000) begin
      n_errors++;
      $display("MISMATCH at %0t: timeout", $time);
      end_sim();
    end
  end

  initial begin
    reset_i = 1'b1;
    trst_n_i = 1'b1;
    repeat (16) @(posedge core_clk_i);
    #2 reset_i = 1'b0;
    host.park();
    foreach (rows[i]) begin
      load_ir(rows[i].code);
      host.scan(1'b0, rows[i].n, rows[i].din, d);
      repeat (8) @(posedge core_clk_i);
      cmp(d, rows[i].dout, "chain out");
      cmp({16'h0, bnd}, {16'h0, rows[i].bnd}, "boundary hold");
      cmp(data, rows[i].nd, "node data");
      $display("row %0d done", i);
    end
    cmp({25'h0, addr}, 32'h5, "node addr");
    cmp({24'h0, instr}, 32'h77, "node instr");
    cmp(n_strobes, 32'h3, "strobe count");
    // five tms ones fall back to the id chain
    load_ir(4'hf);
    host.park();
    host.scan(1'b0, 32, 32'h0, d);
    cmp(d, ID, "id after tms reset");
    $display("tms reset done");
    // test reset in the middle of a boundary shift
    load_ir(4'h0);
    host.step(1'b1, ~tdi, q);
    repeat (4) host.step(1'b0, ~tdi, q);
    @(posedge core_clk_i);
    #2 trst_n_i = 1'b0;
    @(posedge core_clk_i);
    cmp({31'h0, tdo_oe}, 32'h0, "tdo enable in reset");
    cmp({16'h0, bnd}, 32'h0, "boundary in reset");
    #2 trst_n_i = 1'b1;
    host.park();
    host.scan(1'b0, 32, 32'h0, d);
    cmp(d, ID, "id after test reset");
    cmp(n_strobes, 32'h3, "no strobe from test reset");
    cmp(data, 32'h2468_ace0, "node data kept over test reset");
    $display("test reset done");
    @(posedge core_clk_i);
    #2 reset_i = 1'b1;
    @(posedge core_clk_i);
    cmp(data, 32'h0, "node data in reset");
    cmp({31'h0, strobe}, 32'h0, "strobe in reset");
    #2 reset_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    $display("core reset done");
    end_sim();
  end
endmodule : test_jtag_user_scan_chain
